// ==== dv/serial_flash_programming_port_tb_top.sv ====
// self-checking bench for the serial flash programming port
module serial_flash_programming_port_tb_top
  import sfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cs = 1'b1;
  logic ce = 1'b1;
  logic mstrap = 1'b0;
  logic blank = 1'b1;
  logic core_busy = 1'b0;
  logic [55:0] stored_id = 56'h11_2233_4455_6677;
  wire sclk, rxd, txd, busy, prog_mode, link_sync, id_ok, prog_we, erase_req, refused;
  wire [23:0] faddr;
  wire [7:0] fdata;
  int miscompares = 0;
  int check_count = 0;
  int n_we, n_er, n_ref;
  logic [23:0] we_addr, er_addr;
  logic [7:0] we_data;

  always #25 mclk_i = ~mclk_i;

  sfp_top i_sfp_top (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .code_select_pin_i(cs), .chip_enable_input_i(ce), .mode_strap_input_i(mstrap),
    .serial_clock_pin_i(sclk), .serial_receive_pin_i(rxd),
    .serial_transmit_pin_o(txd), .handshake_hold_output_o(busy),
    .flash_blank_i(blank), .stored_id_i(stored_id), .core_busy_i(core_busy),
    .prog_mode_o(prog_mode), .link_sync_o(link_sync), .id_ok_o(id_ok),
    .prog_we_o(prog_we), .erase_req_o(erase_req), .refused_o(refused),
    .flash_addr_o(faddr), .flash_data_o(fdata)
  );

  sfp_prog_model i_sfp_prog_model (.sclk_o(sclk), .rxd_o(rxd), .txd_i(txd), .busy_i(busy));

  // pulse monitor
  always @(posedge mclk_i) begin
    if (prog_we === 1'b1) begin
      n_we++;
      we_addr = faddr;
      we_data = fdata;
    end
    if (erase_req === 1'b1) begin
      n_er++;
      er_addr = faddr;
    end
    if (refused === 1'b1) n_ref++;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang(input string what);
    miscompares++;
    $display("[ERR] %0t no answer: %s", $time, what);
    end_of_test();
  endtask

  task automatic settle();
    repeat (10) @(posedge mclk_i);
  endtask

  task automatic do_reset(input logic sync, input logic empty);
    int n;
    @(posedge mclk_i);
    sys_rst_i <= 1'b1;
    blank <= empty;
    core_busy <= 1'b0;
    i_sfp_prog_model.strap(sync);
    repeat (20) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    n = 0;
    while (prog_mode !== 1'b1 && n < 50) begin
      @(posedge mclk_i);
      n++;
    end
    if (n == 50) hang("mode latch");
    settle();
    n_we = 0;
    n_er = 0;
    n_ref = 0;
  endtask

  task automatic sendr(input logic [7:0] b, output logic [7:0] r);
    bit ok;
    i_sfp_prog_model.xfer(b, r, ok);
    if (!ok) hang("busy stuck high");
  endtask

  task automatic send_q(input logic [7:0] q[$]);
    logic [7:0] r;
    foreach (q[i]) sendr(q[i], r);
    settle();
  endtask

  task automatic send_id(input logic [7:0] flip);
    send_q({CMD_ID_CHECK, 8'hDF, 8'hFF, 8'h0F, 8'h07});
    for (int k = 0; k < 7; k++) send_q({stored_id[8*k+:8] ^ (k == 6 ? flip : 8'h00)});
  endtask

  task automatic t_sync_status();
    logic [7:0] r;
    do_reset(1'b1, 1'b1);
    chk_bit(prog_mode, 1'b1);
    chk_bit(link_sync, 1'b1);
    chk_bit(busy, 1'b0);
    sendr(CMD_READ_STAT, r);
    sendr(8'h00, r);
    chk_val(24'(r), 24'(STAT_RST));
  endtask

  task automatic t_busy();
    logic [7:0] r;
    do_reset(1'b1, 1'b1);
    sendr(CMD_READ_STAT, r);
    chk_bit(busy, 1'b1);
    @(posedge mclk_i);
    core_busy <= 1'b1;
    settle();
    chk_bit(busy, 1'b1);
    core_busy <= 1'b0;
    sendr(8'h00, r);
    chk_val(24'(r), 24'(STAT_RST));
    chk_bit(link_sync, 1'b1);
  endtask

  task automatic t_gate();
    do_reset(1'b1, 1'b0);
    send_q({CMD_PAGE_PROG});
    chk_val(24'(n_ref), 24'd1);
    send_id(8'h01);
    chk_bit(id_ok, 1'b0);
    send_q({CMD_BLOCK_ERASE});
    chk_val(24'(n_ref), 24'd2);
    send_id(8'h00);
    chk_bit(id_ok, 1'b1);
    send_q({CMD_BLOCK_ERASE, 8'h34, 8'h12, CMD_CONFIRM});
    chk_val(24'(n_er), 24'd1);
    chk_val({8'h00, er_addr[23:8]}, 24'h00_1234);
    send_q({CMD_BLOCK_ERASE, 8'hE0, 8'h0D, CMD_CONFIRM});
    chk_val(24'(n_er), 24'd1);
    chk_val(24'(n_ref), 24'd3);
  endtask

  task automatic t_prog();
    do_reset(1'b1, 1'b1);
    send_q({CMD_PAGE_PROG, 8'h10, 8'h00, 8'hAA, 8'h55});
    chk_val(24'(n_we), 24'd2);
    chk_val(we_addr, 24'h00_1001);
    chk_val(24'(we_data), 24'h55);
    do_reset(1'b1, 1'b1);
    send_q({CMD_PAGE_PROG, 8'hE5, 8'h0D, 8'h11});
    chk_val(24'(n_we), 24'd0);
    chk_val(24'(n_ref), 24'd1);
  endtask

  task automatic t_async();
    logic [7:0] r;
    bit ok;
    do_reset(1'b0, 1'b1);
    chk_bit(link_sync, 1'b0);
    chk_bit(busy, 1'b1);
    i_sfp_prog_model.strap(1'b1);
    settle();
    chk_bit(link_sync, 1'b0);
    i_sfp_prog_model.strap(1'b0);
    fork
      i_sfp_prog_model.uart_tx(CMD_READ_STAT);
      i_sfp_prog_model.uart_rx(r, ok);
    join
    if (!ok) hang("uart answer");
    chk_val(24'(r), 24'(STAT_RST));
  endtask

  initial begin
    t_sync_status();
    t_busy();
    t_gate();
    t_prog();
    t_async();
    end_of_test();
  end
endmodule // serial_flash_programming_port_tb_top

// ==== dv/sfp_prog_model.sv ====
// behavioural programmer unit on the far side of the serial channel
module sfp_prog_model (
  // link pins
  output logic sclk_o,
  output logic rxd_o,
  input wire logic txd_i,
  input wire logic busy_i
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam realtime HALF = 62.5;
  localparam realtime UBIT = 104167.0;

  initial begin
    sclk_o = 1'b1;
    rxd_o = 1'b1;
  end

  // level of the clock pin while reset is released
  task automatic strap(input logic lvl);
    sclk_o = lvl;
  endtask

  // one clocked byte, once busy is low or after 4000 polls of busy
  task automatic xfer(input logic [7:0] b, output logic [7:0] r, output bit ok);
    int n;
    n = 0;
    while (busy_i !== 1'b0 && n < 4000) begin
      #50;
      n++;
    end
    ok = (n < 4000);
    // keep the first fall off the main clock edge that updates the transmit byte
    #HALF;
    for (int i = 0; i < 8; i++) begin
      sclk_o = 1'b0;
      rxd_o = b[i];
      #HALF;
      sclk_o = 1'b1;
      r[i] = txd_i;
      #HALF;
    end
    // released line must not keep the last bit
    rxd_o = ~b[7];
  endtask

  // 8n1 frame towards the device
  task automatic uart_tx(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o = f[i];
      #UBIT;
    end
  endtask

  // 8n1 frame from the device, sampled mid bit
  task automatic uart_rx(output logic [7:0] r, output bit ok);
    int n;
    n = 0;
    while (txd_i !== 1'b0 && n < 60000) begin
      #50;
      n++;
    end
    ok = (n < 60000);
    #(UBIT * 1.5);
    for (int i = 0; i < 8; i++) begin
      r[i] = txd_i;
      #UBIT;
    end
  endtask
endmodule // sfp_prog_model

// ==== hw/sfp_pkg.sv ====
// constants and types shared by the serial flash programming port
package sfp_pkg;
  // timing
  localparam int unsigned MCLK_PERIOD_NS = 32'h0000_0032;
  localparam int unsigned UART_BIT_NS = 32'h0001_96E7;
  localparam int unsigned UART_BIT_CYC = UART_BIT_NS / MCLK_PERIOD_NS;
  localparam logic [11:0] BIT_CYC = 12'(UART_BIT_CYC - 32'h0000_0001);
  localparam logic [11:0] HALF_CYC = 12'(UART_BIT_CYC / 32'h0000_0002);
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // framing
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] UART_STOP = 4'h9;
  localparam logic [2:0] ID_LEN = 3'h7;
  localparam logic [1:0] ID_ADDR_LAST = 2'h2;
  localparam logic [7:0] PAGE_LAST = 8'hFF;
  // command codes
  localparam logic [7:0] CMD_ID_CHECK = 8'hF5;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h41;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
  localparam logic [7:0] CMD_READ_STAT = 8'h70;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  // boot area pages (address bits 23..8)
  localparam logic [15:0] BOOT_PAGE_LO = 16'h0DE0;
  localparam logic [15:0] BOOT_PAGE_HI = 16'h0DFF;
  // status byte
  localparam logic [7:0] STAT_RST = 8'h80;
  localparam int unsigned ST_READY = 32'h0000_0007;
  localparam int unsigned ST_ERASE_ERR = 32'h0000_0005;
  localparam int unsigned ST_PROG_ERR = 32'h0000_0004;
  localparam int unsigned ST_ID_OK = 32'h0000_0003;
  localparam logic [1:0] STAT_BYTES = 2'h2;

  typedef enum logic [3:0] {
    SFP_IDLE, SFP_ID_ADDR, SFP_ID_SIZE, SFP_ID_DATA, SFP_ADDR_MID, SFP_ADDR_HI,
    SFP_PROG_DATA, SFP_ERASE_CONF, SFP_STAT_OUT
  } sfp_cmd_e;
endpackage

// ==== hw/sfp_sync_link.sv ====
// byte shifter clocked by the programmer's transfer clock
module sfp_sync_link
  import sfp_pkg::*;
(
  // link clock and reset
  input wire logic sclk_i,
  input wire logic sys_rst_i,
  // serial pins
  input wire logic rxd_i,
  output logic txd_o,
  // byte side
  input wire logic [7:0] tx_byte_i,
  output logic [7:0] rx_byte_o,
  output logic rx_tgl_o,
  output logic active_o
);
  logic [2:0] cnt_ff;
  logic [7:0] rsh_ff;
  logic [7:0] tsh_ff;

  // receive on rising edge, lsb first
  always_ff @(posedge sclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_ff <= 3'h0;
      rsh_ff <= 8'h00;
      rx_byte_o <= 8'h00;
      rx_tgl_o <= 1'b0;
      active_o <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 3'h1;
      rsh_ff <= {rxd_i, rsh_ff[7:1]};
      if (cnt_ff == LAST_BIT) begin
        rx_byte_o <= {rxd_i, rsh_ff[7:1]};
        rx_tgl_o <= ~rx_tgl_o;
        active_o <= 1'b0;
      end else begin
        active_o <= 1'b1;
      end
    end
  end

  // transmit changes on falling edge, byte loaded before its first bit
  always_ff @(negedge sclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      txd_o <= 1'b1;
      tsh_ff <= 8'h00;
    end else if (cnt_ff == 3'h0) begin
      txd_o <= tx_byte_i[0];
      tsh_ff <= {1'b0, tx_byte_i[7:1]};
    end else begin
      txd_o <= tsh_ff[0];
      tsh_ff <= {1'b0, tsh_ff[7:1]};
    end
  end

  a_byte_whole: assert property (@(posedge sclk_i) disable iff (sys_rst_i)
    (rx_tgl_o != $past(rx_tgl_o)) |-> ($past(cnt_ff) == LAST_BIT))
    else $error("byte completed off an 8-bit boundary");
endmodule // sfp_sync_link

// ==== hw/sfp_top.sv ====
// serial flash programming port: mode straps, link variants, id gate
module sfp_top
  import sfp_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // strap pins
  input wire logic code_select_pin_i,
  input wire logic chip_enable_input_i,
  input wire logic mode_strap_input_i,
  // serial channel one
  input wire logic serial_clock_pin_i,
  input wire logic serial_receive_pin_i,
  output logic serial_transmit_pin_o,
  output logic handshake_hold_output_o,
  // flash and processor side
  input wire logic flash_blank_i,
  input wire logic [55:0] stored_id_i,
  input wire logic core_busy_i,
  output logic prog_mode_o,
  output logic link_sync_o,
  output logic id_ok_o,
  output logic prog_we_o,
  output logic erase_req_o,
  output logic refused_o,
  output logic [23:0] flash_addr_o,
  output logic [7:0] flash_data_o
);
  logic [2:0] strap_s1_ff, strap_s2_ff, strap_s3_ff;
  logic [1:0] wait_ff;
  logic latched_ff;
  logic [7:0] stat_ff;
  logic [7:0] tx_byte_ff;
  logic [7:0] link_rx_byte;
  logic link_rx_tgl, link_active, link_txd;
  logic tgl_s1_ff, tgl_s2_ff, tgl_s3_ff;
  logic act_s1_ff, act_s2_ff, act_s3_ff;
  logic hold_ff;
  logic rxd_s1_ff, rxd_s2_ff, rxd_s3_ff, rxd_q_ff;
  logic urx_on_ff, urx_evt_ff;
  logic [11:0] urx_cnt_ff;
  logic [3:0] urx_bit_ff;
  logic [7:0] urx_sh_ff;
  logic utx_on_ff, utx_txd_ff;
  logic [11:0] utx_cnt_ff;
  logic [3:0] utx_bit_ff;
  logic [9:0] utx_sh_ff;
  logic utx_go;
  logic rx_evt;
  logic [7:0] rx_byte;
  logic allowed;
  logic active_mode;
  sfp_cmd_e state_ff;
  logic [7:0] idx_ff;
  logic [15:0] page_ff;
  logic match_ff, size_ok_ff, is_prog_ff, boot_ff;
  logic [1:0] left_ff;

  sfp_sync_link u_link (
    .sclk_i(serial_clock_pin_i),
    .sys_rst_i(sys_rst_i),
    .rxd_i(serial_receive_pin_i),
    .txd_o(link_txd),
    .tx_byte_i(tx_byte_ff),
    .rx_byte_o(link_rx_byte),
    .rx_tgl_o(link_rx_tgl),
    .active_o(link_active)
  );

  // strap pins and clock pin synchronised, latched once after release
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_s1_ff <= 3'h0;
      strap_s2_ff <= 3'h0;
      strap_s3_ff <= 3'h0;
      wait_ff <= 2'h0;
      latched_ff <= 1'b0;
      prog_mode_o <= 1'b0;
      link_sync_o <= 1'b0;
    end else begin
      strap_s1_ff <= {serial_clock_pin_i, code_select_pin_i & chip_enable_input_i, mode_strap_input_i};
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
      if (wait_ff != STRAP_WAIT) begin
        wait_ff <= wait_ff + 2'h1;
      end else if (!latched_ff && strap_s2_ff == strap_s3_ff) begin
        latched_ff <= 1'b1;
        prog_mode_o <= strap_s3_ff[1] & ~strap_s3_ff[0];
        link_sync_o <= strap_s3_ff[2];
      end
    end
  end

  assign active_mode = latched_ff & prog_mode_o;

  // byte events from the synchronous link
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
      act_s1_ff <= 1'b0;
      act_s2_ff <= 1'b0;
      act_s3_ff <= 1'b0;
    end else begin
      tgl_s1_ff <= link_rx_tgl;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
      act_s1_ff <= link_active;
      act_s2_ff <= act_s1_ff;
      act_s3_ff <= act_s2_ff;
    end
  end

  // asynchronous receiver: start, 8 data lsb first, stop
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rxd_s1_ff <= 1'b1;
      rxd_s2_ff <= 1'b1;
      rxd_s3_ff <= 1'b1;
      rxd_q_ff <= 1'b1;
      urx_on_ff <= 1'b0;
      urx_evt_ff <= 1'b0;
      urx_cnt_ff <= 12'h000;
      urx_bit_ff <= 4'h0;
      urx_sh_ff <= 8'h00;
    end else begin
      rxd_s1_ff <= serial_receive_pin_i;
      rxd_s2_ff <= rxd_s1_ff;
      rxd_s3_ff <= rxd_s2_ff;
      if (rxd_s2_ff == rxd_s3_ff) begin
        rxd_q_ff <= rxd_s3_ff;
      end
      urx_evt_ff <= 1'b0;
      if (!urx_on_ff) begin
        if (!rxd_q_ff && active_mode && !link_sync_o) begin
          urx_on_ff <= 1'b1;
          urx_cnt_ff <= HALF_CYC;
          urx_bit_ff <= 4'h0;
        end
      end else if (urx_cnt_ff != 12'h000) begin
        urx_cnt_ff <= urx_cnt_ff - 12'h001;
      end else begin
        urx_cnt_ff <= BIT_CYC;
        urx_bit_ff <= urx_bit_ff + 4'h1;
        if (urx_bit_ff == 4'h0 && rxd_q_ff) begin
          urx_on_ff <= 1'b0;
        end else if (urx_bit_ff == UART_STOP) begin
          urx_on_ff <= 1'b0;
          urx_evt_ff <= rxd_q_ff;
        end else if (urx_bit_ff != 4'h0) begin
          urx_sh_ff <= {rxd_q_ff, urx_sh_ff[7:1]};
        end
      end
    end
  end

  // asynchronous transmitter
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      utx_on_ff <= 1'b0;
      utx_txd_ff <= 1'b1;
      utx_cnt_ff <= 12'h000;
      utx_bit_ff <= 4'h0;
      utx_sh_ff <= 10'h3FF;
    end else if (!utx_on_ff) begin
      if (utx_go) begin
        utx_on_ff <= 1'b1;
        utx_sh_ff <= {1'b1, stat_ff, 1'b0};
        utx_cnt_ff <= 12'h000;
        utx_bit_ff <= 4'h0;
      end
    end else if (utx_cnt_ff != 12'h000) begin
      utx_cnt_ff <= utx_cnt_ff - 12'h001;
    end else begin
      utx_cnt_ff <= BIT_CYC;
      utx_txd_ff <= utx_sh_ff[0];
      utx_sh_ff <= {1'b1, utx_sh_ff[9:1]};
      utx_bit_ff <= utx_bit_ff + 4'h1;
      utx_on_ff <= (utx_bit_ff != (UART_STOP + 4'h1));
    end
  end

  assign utx_go = (state_ff == SFP_STAT_OUT) && !link_sync_o && !utx_on_ff && left_ff != 2'h0;
  assign serial_transmit_pin_o = link_sync_o ? link_txd : utx_txd_ff;
  assign rx_evt = active_mode && (link_sync_o ? (tgl_s2_ff != tgl_s3_ff) : urx_evt_ff);
  assign rx_byte = link_sync_o ? link_rx_byte : urx_sh_ff;
  assign allowed = id_ok_o | flash_blank_i;

  // busy handshake, synchronous link only
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_ff <= 1'b0;
      handshake_hold_output_o <= 1'b1;
    end else begin
      if (act_s2_ff && !act_s3_ff && active_mode && link_sync_o) begin
        hold_ff <= 1'b1;
      end else if (rx_evt) begin
        hold_ff <= 1'b0;
      end
      handshake_hold_output_o <= !(active_mode && link_sync_o) || hold_ff || rx_evt
        || core_busy_i || prog_we_o || erase_req_o;
    end
  end

  // command interpreter
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff <= SFP_IDLE;
      idx_ff <= 8'h00;
      page_ff <= 16'h0000;
      match_ff <= 1'b0;
      size_ok_ff <= 1'b0;
      is_prog_ff <= 1'b0;
      boot_ff <= 1'b0;
      left_ff <= 2'h0;
      id_ok_o <= 1'b0;
      refused_o <= 1'b0;
    end else begin
      refused_o <= 1'b0;
      case (state_ff)
        SFP_IDLE: begin
          if (rx_evt) begin
            idx_ff <= 8'h00;
            if (rx_byte == CMD_ID_CHECK) begin
              state_ff <= SFP_ID_ADDR;
            end else if (rx_byte == CMD_READ_STAT) begin
              state_ff <= SFP_STAT_OUT;
              left_ff <= STAT_BYTES;
            end else if ((rx_byte == CMD_PAGE_PROG || rx_byte == CMD_BLOCK_ERASE) && allowed) begin
              state_ff <= SFP_ADDR_MID;
              is_prog_ff <= (rx_byte == CMD_PAGE_PROG);
            end else begin
              refused_o <= 1'b1;
            end
          end
        end
        SFP_ID_ADDR: begin
          if (rx_evt) begin
            idx_ff <= idx_ff + 8'h01;
            if (idx_ff[1:0] == ID_ADDR_LAST) begin
              state_ff <= SFP_ID_SIZE;
            end
          end
        end
        SFP_ID_SIZE: begin
          if (rx_evt) begin
            size_ok_ff <= (rx_byte == {5'h00, ID_LEN});
            match_ff <= 1'b1;
            idx_ff <= 8'h00;
            state_ff <= SFP_ID_DATA;
          end
        end
        SFP_ID_DATA: begin
          if (rx_evt) begin
            idx_ff <= idx_ff + 8'h01;
            if (idx_ff[2:0] == ID_LEN - 3'h1) begin
              id_ok_o <= match_ff && size_ok_ff && rx_byte == stored_id_i[8 * idx_ff[2:0] +: 8];
              state_ff <= SFP_IDLE;
            end else begin
              match_ff <= match_ff && rx_byte == stored_id_i[8 * idx_ff[2:0] +: 8];
            end
          end
        end
        SFP_ADDR_MID: begin
          if (rx_evt) begin
            page_ff[7:0] <= rx_byte;
            state_ff <= SFP_ADDR_HI;
          end
        end
        SFP_ADDR_HI: begin
          if (rx_evt) begin
            page_ff[15:8] <= rx_byte;
            boot_ff <= {rx_byte, page_ff[7:0]} >= BOOT_PAGE_LO && {rx_byte, page_ff[7:0]} <= BOOT_PAGE_HI;
            idx_ff <= 8'h00;
            state_ff <= is_prog_ff ? SFP_PROG_DATA : SFP_ERASE_CONF;
          end
        end
        SFP_PROG_DATA: begin
          if (rx_evt) begin
            idx_ff <= idx_ff + 8'h01;
            refused_o <= boot_ff && idx_ff == 8'h00;
            if (idx_ff == PAGE_LAST) begin
              state_ff <= SFP_IDLE;
            end
          end
        end
        SFP_ERASE_CONF: begin
          if (rx_evt) begin
            refused_o <= boot_ff || rx_byte != CMD_CONFIRM;
            state_ff <= SFP_IDLE;
          end
        end
        SFP_STAT_OUT: begin
          if ((link_sync_o && rx_evt) || utx_go) begin
            left_ff <= left_ff - 2'h1;
          end
          if (left_ff == 2'h0 && !utx_on_ff) begin
            state_ff <= SFP_IDLE;
          end
        end
        default: state_ff <= SFP_IDLE;
      endcase
    end
  end

  // handing rewrite work to the on-chip processor
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prog_we_o <= 1'b0;
      erase_req_o <= 1'b0;
      flash_addr_o <= 24'h00_0000;
      flash_data_o <= 8'h00;
    end else begin
      prog_we_o <= rx_evt && state_ff == SFP_PROG_DATA && !boot_ff;
      erase_req_o <= rx_evt && state_ff == SFP_ERASE_CONF && !boot_ff && rx_byte == CMD_CONFIRM;
      if (rx_evt && (state_ff == SFP_PROG_DATA || state_ff == SFP_ERASE_CONF)) begin
        flash_addr_o <= {page_ff, state_ff == SFP_PROG_DATA ? idx_ff : 8'h00};
        flash_data_o <= rx_byte;
      end
    end
  end

  // status byte and transmit holding register
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_ff <= STAT_RST;
      tx_byte_ff <= 8'hFF;
    end else begin
      stat_ff[ST_READY] <= ~core_busy_i;
      stat_ff[ST_ID_OK] <= id_ok_o;
      if (refused_o && is_prog_ff) begin
        stat_ff[ST_PROG_ERR] <= 1'b1;
      end
      if (refused_o && !is_prog_ff) begin
        stat_ff[ST_ERASE_ERR] <= 1'b1;
      end
      tx_byte_ff <= (state_ff == SFP_STAT_OUT) ? stat_ff : 8'hFF;
    end
  end

  a_mode_latched: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $past(latched_ff) |-> $stable(link_sync_o) && $stable(prog_mode_o))
    else $error("link variant changed after latch");
  a_strap_clock: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(latched_ff) |-> link_sync_o == $past(strap_s3_ff[2]))
    else $error("link variant not taken from clock pin level");
  a_busy_byte: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    rx_evt |=> handshake_hold_output_o)
    else $error("busy low right after a byte");
  a_busy_core: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    core_busy_i |=> handshake_hold_output_o)
    else $error("busy low while rewrite runs");
  a_ready_low: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    active_mode && link_sync_o && !hold_ff && !rx_evt && !core_busy_i && !prog_we_o && !erase_req_o
    |=> !handshake_hold_output_o)
    else $error("busy high while ready");
  a_async_nobusy: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    latched_ff && !link_sync_o |=> handshake_hold_output_o && !prog_we_o ##0 !hold_ff)
    else $error("handshake used on asynchronous link");
  a_boot_refused: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    prog_we_o || erase_req_o |-> flash_addr_o[23:8] < BOOT_PAGE_LO || flash_addr_o[23:8] > BOOT_PAGE_HI)
    else $error("boot area rewrite issued");
  a_id_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state_ff == SFP_IDLE && rx_evt && rx_byte == CMD_PAGE_PROG && !id_ok_o && !flash_blank_i
    |=> refused_o && state_ff == SFP_IDLE)
    else $error("command taken without identification");
  a_blank_open: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state_ff == SFP_IDLE && rx_evt && rx_byte == CMD_BLOCK_ERASE && flash_blank_i
    |=> state_ff == SFP_ADDR_MID)
    else $error("blank flash refused a command");
  a_id_seven: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $rose(id_ok_o) |-> $past(state_ff) == SFP_ID_DATA && $past(idx_ff[2:0]) == ID_LEN - 3'h1)
    else $error("identification accepted before seven bytes");

  c_id_pass: cover property (@(posedge mclk_i) disable iff (sys_rst_i) $rose(id_ok_o));
  c_prog_byte: cover property (@(posedge mclk_i) disable iff (sys_rst_i) prog_we_o);
  c_erase: cover property (@(posedge mclk_i) disable iff (sys_rst_i) erase_req_o);
  c_refused: cover property (@(posedge mclk_i) disable iff (sys_rst_i) refused_o);
endmodule // sfp_top
